// File: hw/frame_timer.sv
// down counter of link frames, reports the frame on which it runs out
module frame_timer #(
  parameter int W = 9
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  input wire logic tick_i,
  input wire logic hold_i,
  // status
  output logic done_o
);
  logic [W-1:0] count_q;
  logic busy_q;
  logic last;

  assign last = busy_q && tick_i && !hold_i && count_q <= W'(1);
  assign done_o = last;

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_q <= '0;
      busy_q <= 1'b0;
    end else if (load_i) begin
      count_q <= value_i;
      busy_q <= 1'b1;
    end else if (last) begin
      count_q <= '0;
      busy_q <= 1'b0;
    end else if (busy_q && tick_i && !hold_i) begin
      count_q <= count_q - W'(1);
    end
  end
endmodule // frame_timer

// File: hw/pin_sync.sv
// two-flop synchroniser with edge detection for one outside input
module pin_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin side
  input wire logic pin_i,
  // synchronised side
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~last_q;
  assign fall_o = ~sync_q & last_q;
endmodule // pin_sync

// File: hw/touch_seq_pkg.sv
// constants, types and lookups shared by the touch converter sequencer
package touch_seq_pkg;
  // register indices on the codec register port
  localparam logic [6:0] ADDR_WAKE = 7'h52;
  localparam logic [6:0] ADDR_PIN_STATUS = 7'h54;
  localparam logic [6:0] ADDR_PIN_FUNC = 7'h56;
  localparam logic [6:0] ADDR_MEASURE = 7'h74;
  localparam logic [6:0] ADDR_TIMING = 7'h76;
  localparam logic [6:0] ADDR_MASK_CTRL = 7'h78;
  localparam logic [6:0] ADDR_RESULT = 7'h7a;
  // field positions
  localparam int WAKE_READY_BIT = 12;
  localparam int STATUS_READY_BIT = 12;
  localparam int PIN_FUNC_BIT = 4;
  localparam int PAIR_BIT = 0;
  localparam int SLOT_EN_BIT = 3;
  localparam int SLOT_SEL_LO = 0;
  localparam int SETTLE_LO = 4;
  localparam int RATE_LO = 8;
  localparam int CONT_BIT = 10;
  localparam int GATE_LO = 6;
  localparam int POLL_BIT = 8;
  localparam int POWER_LO = 12;
  // reset values
  localparam logic [15:0] MEASURE_RST = 16'h0000;
  localparam logic [15:0] TIMING_RST = 16'h0006;
  localparam logic [15:0] MASK_CTRL_RST = 16'h0000;
  localparam logic [15:0] WAKE_RST = 16'h0000;
  localparam logic [15:0] PIN_FUNC_RST = 16'h01fc;
  // codes
  localparam logic [3:0] SETTLE_NONE = 4'hf;
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_X = 3'h1;
  localparam logic [2:0] SRC_Y = 3'h2;
  localparam logic [2:0] SRC_PRESS = 3'h3;
  localparam logic [1:0] GATE_OFF = 2'h0;
  localparam logic [1:0] GATE_LEVEL = 2'h1;
  localparam logic [1:0] GATE_EDGE = 2'h2;
  localparam logic [1:0] GATE_SYNC = 2'h3;
  localparam int PAIR_GROUP = 3;
  localparam logic [8:0] CONV_FRAMES = 9'h001;
  localparam logic [8:0] PRESS_FRAMES = 9'h002;

  typedef struct packed {
    logic pen;
    logic [2:0] src;
    logic [11:0] data;
  } result_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GATE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CONV = 3'b011,
    ST_DONE = 3'b100
  } seq_state_t;

  // frames of settling wait per code
  function automatic logic [8:0] settle_frames(input logic [3:0] code);
    case (code)
      4'h0: settle_frames = 9'h001;
      4'h1: settle_frames = 9'h002;
      4'h2: settle_frames = 9'h004;
      4'h3: settle_frames = 9'h008;
      4'h4: settle_frames = 9'h010;
      4'h5: settle_frames = 9'h020;
      4'h6: settle_frames = 9'h030;
      4'h7: settle_frames = 9'h040;
      4'h8: settle_frames = 9'h060;
      4'h9: settle_frames = 9'h080;
      4'ha: settle_frames = 9'h0a0;
      4'hb: settle_frames = 9'h0c0;
      4'hc: settle_frames = 9'h0e0;
      4'hd: settle_frames = 9'h100;
      4'he: settle_frames = 9'h120;
      default: settle_frames = 9'h000;
    endcase
  endfunction

  // frames between measurement sets per rate code
  function automatic logic [9:0] rate_frames(input logic [1:0] code);
    case (code)
      2'h0: rate_frames = 10'h200;
      2'h1: rate_frames = 10'h190;
      2'h2: rate_frames = 10'h138;
      default: rate_frames = 10'h100;
    endcase
  endfunction
endpackage

// File: hw/touch_settle_sequencer.sv
// touch and auxiliary converter sequencer: settling, gating, ready flag
// Operation
// - settle code 0-5 waits 1..32 frames, 6-14 waits 48..288 frames
// - code all ones: no wait, drive held on, sampling starts at once
// - measurement ends settle plus one frame, pressure plus two frames
// - zero-settle code forces single measurements despite pair mode
// - zero-settle with X, Y or pressure keeps panel drive always on
// - zero-settle in continuous mode samples faster than the rate
// - gate mode 00: mask pin ignored, its input disabled
// - gate mode 01: mask high halts conversions, low has no effect
// - gate mode 10: mask edges postpone conversions by settle wait
// - gate mode 11: each conversion waits for a mask edge, except with the zero-settle code
// - ready flag holds until result read, or sent in slot
// - flag after every conversion, or after three in pair mode
// - flag raises wake request only when its wake enable is set
// - flag drives shared pin only when pin function select is zero
// - pin status reads return the ready flag at bit 12
// - continuous mode cycles aux1..aux4 in order; polling runs the same set once
// - select register: aux4..aux1 at bits 7..4, pair mode bit 0
// - rate code 00..11 starts a set every 512/400/312/256 frames
// - result carries 3-bit source code, 12-bit sample, pen bit
module touch_settle_sequencer
  import touch_seq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // codec register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // link frame sync and slot return
  input wire logic frame_sync_i,
  input wire logic slot_sent_i,
  output logic slot_valid_o,
  output logic [2:0] slot_number_o,
  output touch_seq_pkg::result_word_t slot_word_o,
  // converter and panel drive
  input wire logic [11:0] adc_data_i,
  input wire logic pen_down_i,
  output logic drive_on_o,
  output logic adc_sample_o,
  output logic [2:0] adc_source_o,
  // shared mask / ready pin and wake request
  input wire logic gate_pin_i,
  output logic ready_pin_o,
  output logic ready_pin_oe_o,
  output logic wake_req_o
);
  import touch_seq_pkg::*;

  logic [15:0] measure_q;
  logic [15:0] timing_q;
  logic [15:0] mask_ctrl_q;
  logic [15:0] wake_q;
  logic [15:0] pin_func_q;
  logic poll_q;
  seq_state_t state_q;
  logic [2:0] src_q;
  logic [2:0] extra_q;
  logic [1:0] item_q;
  logic [9:0] rate_cnt_q;
  logic rate_hit_q;
  logic result_ready_flag_q;
  result_word_t res_q [PAIR_GROUP];
  logic [1:0] rd_idx_q;
  logic [1:0] res_last_q;

  logic frame_tick;
  logic gate_level;
  logic gate_rise;
  logic gate_fall;
  logic gate_edge;
  logic [3:0] settle_wait_code;
  logic [1:0] gate_input_mode;
  logic [1:0] conversion_rate;
  logic [2:0] return_slot_select;
  logic [1:0] converter_power_mode;
  logic [7:1] measure_select;
  logic continuous_mode;
  logic slot_return_enable;
  logic pair_eff;
  logic zero_settle;
  logic halted;
  logic start_set;
  logic tmr_load;
  logic [8:0] tmr_value;
  logic tmr_done;
  logic conv_done;
  logic [2:0] first_src;
  logic [2:0] next_src;
  logic [2:0] next_extra;
  logic set_end;
  logic result_read;
  logic result_take;
  logic flag_set;

  assign settle_wait_code = timing_q[SETTLE_LO +: 4];
  assign conversion_rate = timing_q[RATE_LO +: 2];
  assign continuous_mode = timing_q[CONT_BIT];
  assign slot_return_enable = timing_q[SLOT_EN_BIT];
  assign return_slot_select = timing_q[SLOT_SEL_LO +: 3];
  assign gate_input_mode = mask_ctrl_q[GATE_LO +: 2];
  assign converter_power_mode = mask_ctrl_q[POWER_LO +: 2];
  assign measure_select = measure_q[7:1];
  assign zero_settle = settle_wait_code == SETTLE_NONE;
  assign pair_eff = measure_q[PAIR_BIT] && !zero_settle;

  // frame sync and mask pin cross into mclk first
  pin_sync u_frame_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_i(frame_sync_i),
    .level_o(),
    .rise_o(frame_tick),
    .fall_o()
  );

  pin_sync u_gate_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_i(gate_pin_i),
    .level_o(gate_level),
    .rise_o(gate_rise),
    .fall_o(gate_fall)
  );

  // mask pin has no effect in mode 00
  assign gate_edge = (gate_rise | gate_fall) &&
    gate_input_mode != GATE_OFF;
  assign halted = gate_input_mode == GATE_LEVEL && gate_level;

  // first enabled source above a given one, zero if none
  function automatic logic [2:0] next_enabled(input logic [7:1] sel,
                                              input logic [2:0] after);
    logic [2:0] r;
    r = SRC_NONE;
    for (int i = 7; i >= 1; i--) begin
      if (sel[i] && 3'(i) > after) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // pair mode extra measurement alternates among enabled sources
  always_comb begin
    next_extra = next_enabled(measure_select, extra_q);
    if (next_extra == SRC_NONE) begin
      next_extra = next_enabled(measure_select, SRC_NONE);
    end
    if (pair_eff) begin
      first_src = SRC_X;
    end else begin
      first_src = next_enabled(measure_select, SRC_NONE);
    end
    if (pair_eff) begin
      next_src = item_q == 2'd0 ? SRC_Y : next_extra;
      set_end = item_q == 2'(PAIR_GROUP - 1);
    end else begin
      next_src = next_enabled(measure_select, src_q);
      set_end = next_src == SRC_NONE;
    end
  end

  // set start: rate tick in continuous mode, back to back when no settle
  assign start_set = state_q == ST_IDLE && !halted &&
    converter_power_mode != 2'h0 && measure_select != 7'h00 &&
    (poll_q || (continuous_mode && (rate_hit_q || zero_settle)));

  always_ff @(posedge mclk) begin
    if (rst) begin
      rate_cnt_q <= '0;
      rate_hit_q <= 1'b0;
    end else begin
      if (start_set) begin
        rate_hit_q <= 1'b0;
      end
      if (frame_tick && continuous_mode) begin
        if (rate_cnt_q >= rate_frames(conversion_rate) - 10'd1) begin
          rate_cnt_q <= '0;
          rate_hit_q <= 1'b1;
        end else begin
          rate_cnt_q <= rate_cnt_q + 10'd1;
        end
      end else if (!continuous_mode) begin
        rate_cnt_q <= '0;
        rate_hit_q <= 1'b0;
      end
    end
  end

  // one timer serves settling and conversion time
  always_comb begin
    tmr_load = 1'b0;
    tmr_value = settle_frames(settle_wait_code);
    if (state_q == ST_SETTLE && gate_edge &&
        gate_input_mode == GATE_EDGE) begin
      tmr_load = 1'b1;
    end else if (state_q == ST_SETTLE && tmr_done) begin
      tmr_load = 1'b1;
      tmr_value = src_q == SRC_PRESS ? PRESS_FRAMES : CONV_FRAMES;
    end else if (state_q == ST_GATE && gate_edge) begin
      tmr_load = 1'b1;
    end else if (state_q == ST_DONE && !set_end) begin
      tmr_load = gate_input_mode != GATE_SYNC && !zero_settle;
    end else if (start_set) begin
      tmr_load = gate_input_mode != GATE_SYNC && !zero_settle;
    end
    if ((start_set || (state_q == ST_DONE && !set_end)) && zero_settle) begin
      tmr_load = 1'b1;
      tmr_value = (start_set ? first_src : next_src) == SRC_PRESS ?
        PRESS_FRAMES : CONV_FRAMES;
    end
  end

  frame_timer #(.W(9)) u_timer (
    .mclk(mclk),
    .rst(rst),
    .load_i(tmr_load),
    .value_i(tmr_value),
    .tick_i(frame_tick),
    .hold_i(halted),
    .done_o(tmr_done)
  );

  assign conv_done = state_q == ST_CONV && tmr_done;

  // measurement sequencing
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      src_q <= SRC_NONE;
      extra_q <= SRC_NONE;
      item_q <= 2'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_set) begin
            src_q <= first_src;
            item_q <= 2'd0;
            if (zero_settle) begin
              state_q <= ST_CONV;
            end else if (gate_input_mode == GATE_SYNC) begin
              state_q <= ST_GATE;
            end else begin
              state_q <= ST_SETTLE;
            end
          end
        end
        ST_GATE: begin
          if (gate_edge) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (tmr_done && !tmr_load_restart()) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (pair_eff && item_q == 2'(PAIR_GROUP - 1)) begin
            extra_q <= src_q;
          end
          if (set_end) begin
            state_q <= ST_IDLE;
          end else begin
            src_q <= next_src;
            item_q <= item_q + 2'd1;
            if (zero_settle) begin
              state_q <= ST_CONV;
            end else if (gate_input_mode == GATE_SYNC) begin
              state_q <= ST_GATE;
            end else begin
              state_q <= ST_SETTLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // an edge restart wins over the settling end in the same cycle
  function automatic logic tmr_load_restart();
    return gate_edge && gate_input_mode == GATE_EDGE;
  endfunction

  // results and ready flag
  assign result_read = reg_rd_i && reg_addr_i == ADDR_RESULT &&
    !slot_return_enable;
  assign result_take = result_read || (slot_return_enable && slot_sent_i);
  assign flag_set = state_q == ST_DONE &&
    (!pair_eff || item_q == 2'(PAIR_GROUP - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < PAIR_GROUP; i++) begin
        res_q[i] <= '0;
      end
      rd_idx_q <= 2'd0;
      res_last_q <= 2'd0;
      result_ready_flag_q <= 1'b0;
    end else begin
      if (conv_done) begin
        res_q[pair_eff ? item_q : 2'd0] <=
          '{pen: pen_down_i, src: src_q, data: adc_data_i};
      end
      if (flag_set) begin
        result_ready_flag_q <= 1'b1;
        rd_idx_q <= 2'd0;
        res_last_q <= pair_eff ? 2'(PAIR_GROUP - 1) : 2'd0;
      end else if (result_take && result_ready_flag_q) begin
        if (rd_idx_q == res_last_q) begin
          result_ready_flag_q <= 1'b0;
        end else begin
          rd_idx_q <= rd_idx_q + 2'd1;
        end
      end
    end
  end

  // register writes; poll bit self-clears when its set ends
  always_ff @(posedge mclk) begin
    if (rst) begin
      measure_q <= MEASURE_RST;
      timing_q <= TIMING_RST;
      mask_ctrl_q <= MASK_CTRL_RST;
      wake_q <= WAKE_RST;
      pin_func_q <= PIN_FUNC_RST;
      poll_q <= 1'b0;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          ADDR_MEASURE: measure_q <= {8'h00, reg_wdata_i[7:0]};
          ADDR_TIMING: timing_q <= reg_wdata_i;
          ADDR_MASK_CTRL: mask_ctrl_q <= reg_wdata_i;
          ADDR_WAKE: wake_q <= reg_wdata_i;
          ADDR_PIN_FUNC: pin_func_q <= reg_wdata_i;
          default: ;
        endcase
      end
      if (reg_wr_i && reg_addr_i == ADDR_MASK_CTRL) begin
        poll_q <= reg_wdata_i[POLL_BIT];
      end else if (state_q == ST_DONE && set_end) begin
        poll_q <= 1'b0;
      end
    end
  end

  // register reads, answered one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_MEASURE: reg_rdata_o <= measure_q;
        ADDR_TIMING: reg_rdata_o <= timing_q;
        ADDR_MASK_CTRL: begin
          reg_rdata_o <= mask_ctrl_q;
          reg_rdata_o[POLL_BIT] <= poll_q;
        end
        ADDR_WAKE: reg_rdata_o <= wake_q;
        ADDR_PIN_FUNC: reg_rdata_o <= pin_func_q;
        ADDR_PIN_STATUS: begin
          reg_rdata_o <= '0;
          reg_rdata_o[STATUS_READY_BIT] <= result_ready_flag_q;
        end
        ADDR_RESULT: reg_rdata_o <= res_q[rd_idx_q];
        default: reg_rdata_o <= '0;
      endcase
    end
  end

  // pins, drive and converter outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      drive_on_o <= 1'b0;
      adc_sample_o <= 1'b0;
      adc_source_o <= SRC_NONE;
      ready_pin_o <= 1'b0;
      ready_pin_oe_o <= 1'b0;
      wake_req_o <= 1'b0;
      slot_valid_o <= 1'b0;
      slot_number_o <= 3'h0;
      slot_word_o <= '0;
    end else begin
      drive_on_o <= (src_q <= SRC_PRESS && src_q != SRC_NONE &&
        (state_q == ST_SETTLE || state_q == ST_CONV)) ||
        (zero_settle && measure_select[3:1] != 3'h0);
      adc_sample_o <= (state_q == ST_SETTLE && tmr_done &&
        !tmr_load_restart()) || (zero_settle && tmr_load &&
        state_q != ST_CONV);
      adc_source_o <= src_q;
      ready_pin_oe_o <= !pin_func_q[PIN_FUNC_BIT];
      ready_pin_o <= result_ready_flag_q &&
        !pin_func_q[PIN_FUNC_BIT];
      wake_req_o <= result_ready_flag_q && wake_q[WAKE_READY_BIT];
      slot_valid_o <= result_ready_flag_q && slot_return_enable &&
        !(slot_sent_i && rd_idx_q == res_last_q);
      slot_number_o <= return_slot_select;
      slot_word_o <= res_q[rd_idx_q];
    end
  end
endmodule // touch_settle_sequencer

// File: verif/link_host_model.sv
// link controller stand-in: free running frame sync and slot acceptance
module link_host_model (
  // clock
  input wire logic mclk,
  // slot return
  input wire logic ack_en,
  input wire logic slot_valid,
  output logic slot_sent,
  // frame timing
  output logic frame_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  int w = 0;
  initial begin
    frame_sync = 1'b0;
    #7;
    forever #200 frame_sync = ~frame_sync;
  end
  // takes a waiting word a few cycles late, once per word
  always @(negedge mclk) begin
    w = (ack_en && slot_valid && !slot_sent) ? w + 1 : 0;
    slot_sent <= w == 6;
  end
endmodule // link_host_model

// File: verif/touch_settle_sequencer_sva.sv
// port checker for the touch converter sequencer
module touch_seq_chk
  import touch_seq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  // link side
  input wire logic slot_sent_i,
  input wire logic slot_valid_o,
  input wire logic [2:0] slot_number_o,
  // converter and shared pin
  input wire logic gate_pin_i,
  input wire logic adc_sample_o,
  input wire logic ready_pin_o,
  input wire logic ready_pin_oe_o,
  input wire logic wake_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wen_q;
  logic lvl_q;
  logic [2:0] sl_q;
  logic take;
  assign take = (reg_rd_i && reg_addr_i == ADDR_RESULT) || slot_sent_i;
  // shadows of the control bits the outputs depend on
  always_ff @(posedge mclk) begin
    if (rst) begin
      wen_q <= 1'b0;
      lvl_q <= 1'b0;
      sl_q <= 3'h6;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_WAKE) wen_q <= reg_wdata_i[WAKE_READY_BIT];
      if (reg_addr_i == ADDR_MASK_CTRL) lvl_q <= reg_wdata_i[7:6] == 2'h1;
      if (reg_addr_i == ADDR_TIMING) sl_q <= reg_wdata_i[2:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_sample_one_cycle: assert property (
    adc_sample_o |=> !adc_sample_o) else $error("sample pulse too long");
  chk_pin_off_low: assert property (
    !ready_pin_oe_o |-> !ready_pin_o) else $error("pin driven while off");
  chk_wake_needs_enable: assert property (
    !$past(wen_q) |-> !wake_req_o) else $error("wake without enable");
  chk_wake_tracks_flag: assert property (
    wen_q && $past(wen_q) && ready_pin_oe_o |-> wake_req_o == ready_pin_o)
    else $error("wake differs from flag");
  chk_status_shows_flag: assert property (
    reg_rd_i && reg_addr_i == ADDR_PIN_STATUS && wen_q && $past(wen_q)
    |=> reg_rdata_o[STATUS_READY_BIT] == wake_req_o)
    else $error("status bit differs from flag");
  chk_level_gate_halts: assert property (
    (lvl_q && gate_pin_i) [*5] |-> !adc_sample_o)
    else $error("sample while mask high");
  chk_slot_number_copy: assert property (
    !$past(rst) |-> slot_number_o == $past(sl_q))
    else $error("slot number wrong");
  chk_flag_holds: assert property (
    ready_pin_oe_o && $past(ready_pin_oe_o) && $past(ready_pin_o)
    && !$past(take, 2) |-> ready_pin_o) else $error("flag dropped early");
  chk_select_upper_zero: assert property (
    reg_rd_i && reg_addr_i == ADDR_MEASURE |=> reg_rdata_o[15:8] == 8'h00)
    else $error("select upper byte set");
  cover property (wake_req_o && ready_pin_oe_o);
  cover property (slot_sent_i && slot_valid_o);
  cover property (lvl_q && $fell(gate_pin_i));
endmodule // touch_seq_chk

bind touch_settle_sequencer touch_seq_chk chk (.mclk(mclk), .rst(rst),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .slot_sent_i(slot_sent_i), .slot_valid_o(slot_valid_o),
  .slot_number_o(slot_number_o), .gate_pin_i(gate_pin_i),
  .adc_sample_o(adc_sample_o), .ready_pin_o(ready_pin_o),
  .ready_pin_oe_o(ready_pin_oe_o), .wake_req_o(wake_req_o));

// File: verif/touch_settle_sequencer_tb.sv
// self-checking bench for the touch converter sequencer
module touch_settle_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import touch_seq_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pen = 1'b0;
  logic gdrv = 1'b0, ack = 1'b0, fs, ss, sv, drv, smp, rp, roe, wk;
  logic [6:0] addr = 7'h00;
  logic [15:0] wd = 16'h0000, rdata;
  logic [11:0] adc = 12'h123;
  logic [2:0] sn, src;
  result_word_t sw;
  logic [2:0] obs;
  int err_total = 0, n_compared = 0, ns = 0;
  int rt[4] = '{512, 400, 312, 256};
  wire logic gp = roe ? rp : gdrv;
  assign obs = {sv, wk, smp};
  always #25 mclk = ~mclk;
  always @(posedge mclk) if (smp === 1'b1) ns++;
  touch_settle_sequencer DUT (.mclk(mclk), .rst(rst), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .frame_sync_i(fs), .slot_sent_i(ss), .slot_valid_o(sv),
    .slot_number_o(sn), .slot_word_o(sw), .adc_data_i(adc),
    .pen_down_i(pen), .drive_on_o(drv), .adc_sample_o(smp),
    .adc_source_o(src), .gate_pin_i(gp), .ready_pin_o(rp),
    .ready_pin_oe_o(roe), .wake_req_o(wk));
  link_host_model host (.mclk(mclk), .ack_en(ack), .slot_valid(sv),
    .slot_sent(ss), .frame_sync(fs));
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic ck(string n, logic [15:0] s, logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wrr(logic [6:0] a, logic [15:0] d);
    @(negedge mclk);
    wr = 1'b1;
    addr = a;
    wd = d;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rdr(logic [6:0] a, output logic [15:0] d);
    @(negedge mclk);
    rd = 1'b1;
    addr = a;
    @(negedge mclk);
    rd = 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  // wait for smp (0), wk (1) or sv (2) to reach v, counting cycles
  task automatic wt(int k, logic v, output int c);
    c = 0;
    while (obs[k] !== v) begin
      @(negedge mclk);
      c++;
      if (c > 6000) begin
        err_total++;
        $display("unexpected timeout exp %h got %h", v, obs[k]);
        tally_and_finish();
      end
    end
  endtask
  // settle wait in frames per code
  function automatic int ef(int k);
    return k < 6 ? 1 << k : k < 7 ? 48 : k < 15 ? 64 + 32 * (k - 7) : 0;
  endfunction
  task automatic al;
    @(posedge fs);
    repeat (4) @(negedge mclk);
  endtask
  task automatic regs;
    logic [6:0] a[7] = '{7'h74, 7'h76, 7'h78, 7'h52, 7'h56, 7'h7a, 7'h20};
    logic [15:0] e[7] = '{0, 16'h0006, 0, 0, 16'h01fc, 0, 0};
    logic [15:0] d;
    for (int i = 0; i < 7; i++) begin
      rdr(a[i], d);
      ck("reset value", d, e[i]);
    end
    wrr(ADDR_MEASURE, 16'hffff);
    rdr(ADDR_MEASURE, d);
    ck("select bits", d, 16'h00ff);
    wrr(ADDR_MEASURE, 16'h0000);
    $display("end regs");
  endtask
  task automatic poll(logic [15:0] sel, logic [3:0] k, int f, int fc,
                      logic [2:0] s);
    int c;
    logic [15:0] d;
    adc = adc + 12'h111;
    pen = ~pen;
    wrr(ADDR_MEASURE, sel);
    wrr(ADDR_TIMING, {8'h00, k, 4'h0});
    al();
    wrr(ADDR_MASK_CTRL, 16'h3100);
    wt(0, 1'b1, c);
    ck("settle frames", 16'((c + 4) / 8), 16'(f));
    ck("source", 16'(src), 16'(s));
    wt(1, 1'b1, c);
    ck("conv frames", 16'((c + 4) / 8), 16'(fc));
    rdr(ADDR_RESULT, d);
    ck("result", d, {pen, s, adc});
    rdr(ADDR_PIN_STATUS, d);
    ck("flag clear", 16'(d[12]), 16'h0000);
  endtask
  task automatic pair(logic [3:0] k, int n);
    int c;
    int c0;
    logic [15:0] d;
    wrr(ADDR_PIN_FUNC, 16'h01ec);
    wrr(ADDR_MEASURE, 16'h0009);
    wrr(ADDR_TIMING, {8'h00, k, 4'h0});
    c0 = ns;
    wrr(ADDR_MASK_CTRL, 16'h3100);
    wt(1, 1'b1, c);
    ck("samples per flag", 16'(ns - c0), 16'(n));
    ck("pin flag", {14'h0, roe, rp}, 16'h0003);
    for (int i = 0; i < n; i++) begin
      rdr(ADDR_RESULT, d);
      ck("pair source", 16'(d[14:12]), 16'(n == 1 ? 3 : i + 1));
      rdr(ADDR_PIN_STATUS, d);
      ck("pair flag", 16'(d[12]), 16'(i < n - 1));
    end
    wrr(ADDR_PIN_FUNC, 16'h01fc);
    $display("end pair");
  endtask
  task automatic slot;
    int c;
    logic [15:0] d;
    wrr(ADDR_MEASURE, 16'h0002);
    wrr(ADDR_TIMING, 16'h000a);
    wrr(ADDR_MASK_CTRL, 16'h3100);
    wt(2, 1'b1, c);
    ck("slot word", {5'h0, sn, 5'h0, sw.src},
       {5'h0, 3'h2, 5'h0, SRC_X});
    rdr(ADDR_RESULT, d);
    rdr(ADDR_PIN_STATUS, d);
    ck("flag kept", 16'(d[12]), 16'h0001);
    ack = 1'b1;
    wt(2, 1'b0, c);
    rdr(ADDR_PIN_STATUS, d);
    ck("flag sent", 16'(d[12]), 16'h0000);
    ack = 1'b0;
    wrr(ADDR_TIMING, 16'h0006);
    $display("end slot");
  endtask
  task automatic msk(logic [1:0] m, logic [3:0] k, logic p, int n, int f);
    int c;
    logic [15:0] d;
    gdrv = p;
    wrr(ADDR_TIMING, {8'h00, k, 4'h0});
    al();
    wrr(ADDR_MASK_CTRL, {8'h31, m, 6'h00});
    repeat (n * 8 - 4) @(negedge mclk);
    gdrv = ~p;
    wt(0, 1'b1, c);
    ck("gated frames", 16'((c + n * 8) / 8), 16'(f));
    wt(1, 1'b1, c);
    rdr(ADDR_RESULT, d);
    $display("end mask mode %0d", m);
  endtask
  task automatic cont;
    int c;
    logic [15:0] d;
    wrr(ADDR_MEASURE, 16'h0010);
    wrr(ADDR_MASK_CTRL, 16'h3000);
    for (int r = 0; r < 4; r++) begin
      wrr(ADDR_TIMING, {5'h00, 1'b1, 2'(r), 8'h00});
      wt(0, 1'b1, c);
      @(negedge mclk);
      wt(0, 1'b1, c);
      ck("set period", 16'((c + 5) / 8), 16'(rt[r]));
    end
    wrr(ADDR_MEASURE, 16'h00f0);
    rdr(ADDR_RESULT, d);
    for (int i = 4; i < 8; i++) begin
      wt(1, 1'b1, c);
      rdr(ADDR_RESULT, d);
      ck("aux order", 16'(d[14:12]), 16'(i));
    end
    wrr(ADDR_MEASURE, 16'h0010);
    wrr(ADDR_TIMING, 16'h07f0);
    repeat (20) @(negedge mclk);
    wt(0, 1'b1, c);
    @(negedge mclk);
    wt(0, 1'b1, c);
    ck("fast period", 16'((c + 5) / 8), 16'h0001);
    wrr(ADDR_MEASURE, 16'h0002);
    repeat (40) @(negedge mclk);
    ck("drive held", 16'(drv), 16'h0001);
    wrr(ADDR_TIMING, 16'h0006);
    $display("end continuous");
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    regs();
    wrr(ADDR_WAKE, 16'h1000);
    for (int k = 0; k < 16; k++)
      poll(16'h0002, 4'(k), ef(k), 1, SRC_X);
    for (int b = 2; b < 8; b++)
      poll(16'(1 << b), 4'h0, 1, b == 3 ? 2 : 1, 3'(b));
    $display("end settle");
    pair(4'h0, 3);
    pair(SETTLE_NONE, 1);
    slot();
    wrr(ADDR_MEASURE, 16'h0002);
    msk(GATE_OFF, 4'h0, 1'b1, 1, 1);
    msk(GATE_LEVEL, 4'h0, 1'b1, 6, 7);
    msk(GATE_SYNC, 4'h0, 1'b0, 5, 6);
    msk(GATE_EDGE, 4'h3, 1'b0, 4, 12);
    cont();
    tally_and_finish();
  end
endmodule // touch_settle_sequencer_tb
